// [eeprom_slave_pkg.sv]
// Constants and types shared by the serial EEPROM slave logic
package eeprom_slave_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Memory organisation
    localparam int ADDR_W = 8;
    localparam int PAGE_W = 4;
    localparam int BYTE_W = 8;
    localparam int PAGE_BYTES = 16;
    localparam logic [3:0] BIT_LAST = 4'h8;
    // Arbitrary device type code
    localparam logic [3:0] DEVICE_TYPE_DEF = 4'hA;
    localparam logic RW_READ = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Pin map of the synchronised input group
    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_ADDR_LO = 2;
    localparam int PIN_ADDR_HI = 4;
    localparam int PIN_LOW = 5;
    localparam int PIN_N = 6;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int SYS_CLK_MHZ = 50;
    localparam int LINK_PERIOD_NS = 12;
    localparam int GLITCH_NS = 160;
    // Longest rejected pulse plus margin for sampling phase
    localparam int GLITCH_CYC = GLITCH_NS / LINK_PERIOD_NS + 2;
    localparam int GLITCH_CNT_W = 5;
    localparam int T_INIT_US = 100;
    localparam int T_WRITE_US = 5000;
    localparam int INIT_CYC = T_INIT_US * SYS_CLK_MHZ;
    localparam int WRITE_CYC = T_WRITE_US * SYS_CLK_MHZ;
    localparam int TIMER_W = 20;

    ////////////////////////////////////////////////////////////////////////
    // Link protocol states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RX_DEV,
        ST_ACK_DEV,
        ST_RX_WORD,
        ST_ACK_WORD,
        ST_RX_DATA,
        ST_ACK_DATA,
        ST_TX_DATA,
        ST_TX_ACK,
        ST_IGNORE
    } link_state_e;

endpackage

// [eeprom_serial_slave.sv]
// Two-wire serial EEPROM slave: link protocol, memory, write timing
`timescale 1ns/10ps

// Behaviour
// - Pointer advances on eighth bit falling edge
// - Stop during undervoltage abandons pending write
// - Start then stop returns interface to idle
// - Zero bit or acknowledge holds data low
// - Nine released clocks abandon ack or output
// - Start after dummy clocks resets interface
// - Ignore commands until initialisation completes
// - Write only after data ack then stop
// - Start cancels command unless driving low
// - Data line open drain, never high
// - Reject clock/data pulses up to 160 ns
// - No acknowledge during internal write cycle
// - Page write wraps lower four address bits
// - Sequential read wraps at last address
// - Seven-bit address plus read/write flag
module eeprom_serial_slave #(
    parameter int ADDR_W = eeprom_slave_pkg::ADDR_W,
    parameter logic [3:0] DEVICE_TYPE = eeprom_slave_pkg::DEVICE_TYPE_DEF,
    parameter int INIT_CYCLES = eeprom_slave_pkg::INIT_CYC,
    parameter int WRITE_CYCLES = eeprom_slave_pkg::WRITE_CYC
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_link_clock,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    input wire logic [2:0] i_addr_pins,
    input wire logic i_supply_low,
    output logic o_init_done,
    output logic o_write_busy
);

    localparam int PW = eeprom_slave_pkg::PAGE_W;
    localparam int BW = eeprom_slave_pkg::BYTE_W;
    localparam int NP = eeprom_slave_pkg::PAGE_BYTES;
    localparam int TW = eeprom_slave_pkg::TIMER_W;
    localparam int GW = eeprom_slave_pkg::GLITCH_CNT_W;
    localparam int NPIN = eeprom_slave_pkg::PIN_N;

    ////////////////////////////////////////////////////////////////////////
    // System domain: initialisation and write-cycle timers
    logic [TW-1:0] init_cnt_q;
    logic init_done_q;
    logic [TW-1:0] wr_cnt_q;
    logic busy_q;
    logic tog_meta_q, tog_sync_q, tog_prev_q;
    logic wr_toggle_q;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            init_cnt_q <= '0;
            init_done_q <= 1'b0;
        end else if (!init_done_q) begin
            if (init_cnt_q == TW'(INIT_CYCLES - 1)) begin
                init_done_q <= 1'b1;
            end
            init_cnt_q <= init_cnt_q + 1'b1;
        end
    end

    // Write request arrives as a toggle from the link domain
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            tog_meta_q <= 1'b0;
            tog_sync_q <= 1'b0;
            tog_prev_q <= 1'b0;
        end else begin
            tog_meta_q <= wr_toggle_q;
            tog_sync_q <= tog_meta_q;
            tog_prev_q <= tog_sync_q;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_cnt_q <= '0;
            busy_q <= 1'b0;
        end else if (tog_sync_q != tog_prev_q) begin
            wr_cnt_q <= '0;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (wr_cnt_q == TW'(WRITE_CYCLES - 1)) begin
                busy_q <= 1'b0;
            end
            wr_cnt_q <= wr_cnt_q + 1'b1;
        end
    end

    assign o_init_done = init_done_q;
    assign o_write_busy = busy_q;

    ////////////////////////////////////////////////////////////////////////
    // Link domain: pin synchronisers and status crossings
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_meta_q, pin_sync_q;
    logic [1:0] st_meta_q, st_sync_q;
    logic ready_s, busy_s, low_s;
    logic [2:0] addr_s;

    assign pin_raw = {i_supply_low, i_addr_pins, i_sda, i_scl};

    always_ff @(posedge i_link_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_meta_q <= '1;
            pin_sync_q <= '1;
            st_meta_q <= '0;
            st_sync_q <= '0;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            st_meta_q <= {busy_q, init_done_q};
            st_sync_q <= st_meta_q;
        end
    end

    assign ready_s = st_sync_q[0];
    assign busy_s = st_sync_q[1];
    assign low_s = pin_sync_q[eeprom_slave_pkg::PIN_LOW];
    assign addr_s = pin_sync_q[eeprom_slave_pkg::PIN_ADDR_HI:
                               eeprom_slave_pkg::PIN_ADDR_LO];

    ////////////////////////////////////////////////////////////////////////
    // Glitch filters: a level must hold past the limit to be taken
    logic [1:0] filt_q, prev_q;
    logic [GW-1:0] glitch_cnt_q [2];

    for (genvar g = 0; g < 2; g++) begin : g_filter
        always_ff @(posedge i_link_clock or negedge i_rstn) begin
            if (!i_rstn) begin
                glitch_cnt_q[g] <= '0;
                filt_q[g] <= 1'b1;
                prev_q[g] <= 1'b1;
            end else begin
                prev_q[g] <= filt_q[g];
                if (pin_sync_q[g] == filt_q[g]) begin
                    glitch_cnt_q[g] <= '0;
                end else if (glitch_cnt_q[g] ==
                             GW'(eeprom_slave_pkg::GLITCH_CYC - 1)) begin
                    glitch_cnt_q[g] <= '0;
                    filt_q[g] <= pin_sync_q[g];
                end else begin
                    glitch_cnt_q[g] <= glitch_cnt_q[g] + 1'b1;
                end
            end
        end
    end

    logic scl, sda, scl_rise, scl_fall, start_evt, stop_evt;
    assign scl = filt_q[eeprom_slave_pkg::PIN_SCL];
    assign sda = filt_q[eeprom_slave_pkg::PIN_SDA];
    assign scl_rise = scl & ~prev_q[eeprom_slave_pkg::PIN_SCL];
    assign scl_fall = ~scl & prev_q[eeprom_slave_pkg::PIN_SCL];
    assign start_evt = scl & prev_q[eeprom_slave_pkg::PIN_SCL] &
                       prev_q[eeprom_slave_pkg::PIN_SDA] & ~sda;
    assign stop_evt = scl & prev_q[eeprom_slave_pkg::PIN_SCL] &
                      ~prev_q[eeprom_slave_pkg::PIN_SDA] & sda;

    ////////////////////////////////////////////////////////////////////////
    // Link protocol
    eeprom_slave_pkg::link_state_e state_q;
    logic [3:0] bit_cnt_q;
    logic [BW-1:0] shift_q, tx_q;
    logic [ADDR_W-1:0] ptr_q;
    logic [BW-1:0] page_buf_q [NP];
    logic [NP-1:0] page_valid_q;
    logic wr_any_q, rw_q, nack_q, drive_low_q;
    logic commit;
    logic [BW-1:0] mem_q [2**ADDR_W];
    logic [BW-1:0] rd_data;

    assign rd_data = mem_q[ptr_q];

    // Data must follow an acknowledged byte; stop's own rise counts one
    assign commit = stop_evt && ready_s && !low_s && wr_any_q &&
                    state_q == eeprom_slave_pkg::ST_RX_DATA &&
                    bit_cnt_q <= 4'h1;

    always_ff @(posedge i_link_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= eeprom_slave_pkg::ST_IDLE;
            bit_cnt_q <= '0;
            shift_q <= '0;
            tx_q <= '0;
            ptr_q <= '0;
            page_valid_q <= '0;
            wr_any_q <= 1'b0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            drive_low_q <= 1'b0;
        end else if (!ready_s) begin
            state_q <= eeprom_slave_pkg::ST_IDLE;
            drive_low_q <= 1'b0;
        end else if (start_evt && !drive_low_q) begin
            // Cancels any command; a stuck ack must be clocked out first
            state_q <= eeprom_slave_pkg::ST_RX_DEV;
            bit_cnt_q <= '0;
            page_valid_q <= '0;
            wr_any_q <= 1'b0;
        end else if (stop_evt) begin
            state_q <= eeprom_slave_pkg::ST_IDLE;
            page_valid_q <= '0;
            wr_any_q <= 1'b0;
            drive_low_q <= 1'b0;
        end else begin
            unique case (state_q)
                eeprom_slave_pkg::ST_RX_DEV,
                eeprom_slave_pkg::ST_RX_WORD,
                eeprom_slave_pkg::ST_RX_DATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[BW-2:0], sda};
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                    end else if (scl_fall &&
                                 bit_cnt_q == eeprom_slave_pkg::BIT_LAST) begin
                        bit_cnt_q <= '0;
                        drive_low_q <= 1'b1;
                        if (state_q == eeprom_slave_pkg::ST_RX_DEV) begin
                            if (shift_q[BW-1:1] == {DEVICE_TYPE, addr_s} &&
                                !busy_s) begin
                                rw_q <= shift_q[0];
                                state_q <= eeprom_slave_pkg::ST_ACK_DEV;
                            end else begin
                                drive_low_q <= 1'b0;
                                state_q <= eeprom_slave_pkg::ST_IGNORE;
                            end
                        end else if (state_q == eeprom_slave_pkg::ST_RX_WORD)
                        begin
                            ptr_q <= shift_q[ADDR_W-1:0];
                            state_q <= eeprom_slave_pkg::ST_ACK_WORD;
                        end else begin
                            page_buf_q[ptr_q[PW-1:0]] <= shift_q;
                            page_valid_q[ptr_q[PW-1:0]] <= 1'b1;
                            wr_any_q <= 1'b1;
                            // Page stays fixed; excess bytes overwrite
                            ptr_q[PW-1:0] <= ptr_q[PW-1:0] + 1'b1;
                            state_q <= eeprom_slave_pkg::ST_ACK_DATA;
                        end
                    end
                end
                eeprom_slave_pkg::ST_ACK_DEV: begin
                    if (scl_fall) begin
                        if (rw_q == eeprom_slave_pkg::RW_READ) begin
                            tx_q <= rd_data;
                            drive_low_q <= ~rd_data[BW-1];
                            state_q <= eeprom_slave_pkg::ST_TX_DATA;
                        end else begin
                            drive_low_q <= 1'b0;
                            state_q <= eeprom_slave_pkg::ST_RX_WORD;
                        end
                    end
                end
                eeprom_slave_pkg::ST_ACK_WORD,
                eeprom_slave_pkg::ST_ACK_DATA: begin
                    if (scl_fall) begin
                        drive_low_q <= 1'b0;
                        state_q <= eeprom_slave_pkg::ST_RX_DATA;
                    end
                end
                eeprom_slave_pkg::ST_TX_DATA: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == eeprom_slave_pkg::BIT_LAST - 1'b1)
                        begin
                            bit_cnt_q <= '0;
                            ptr_q <= ptr_q + 1'b1;
                            drive_low_q <= 1'b0;
                            state_q <= eeprom_slave_pkg::ST_TX_ACK;
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 1'b1;
                            tx_q <= {tx_q[BW-2:0], 1'b0};
                            drive_low_q <= ~tx_q[BW-2];
                        end
                    end
                end
                eeprom_slave_pkg::ST_TX_ACK: begin
                    if (scl_rise) begin
                        nack_q <= sda;
                    end else if (scl_fall) begin
                        if (!nack_q) begin
                            tx_q <= rd_data;
                            drive_low_q <= ~rd_data[BW-1];
                            state_q <= eeprom_slave_pkg::ST_TX_DATA;
                        end else begin
                            // Released ninth clock ends output
                            state_q <= eeprom_slave_pkg::ST_IGNORE;
                        end
                    end
                end
                eeprom_slave_pkg::ST_IDLE,
                eeprom_slave_pkg::ST_IGNORE: begin
                    drive_low_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage and write commit
    // Array updated at once; the busy window models cell programming
    always_ff @(posedge i_link_clock) begin
        if (commit) begin
            for (int i = 0; i < NP; i++) begin
                if (page_valid_q[i]) begin
                    mem_q[{ptr_q[ADDR_W-1:PW], PW'(i)}] <= page_buf_q[i];
                end
            end
        end
    end

    always_ff @(posedge i_link_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_toggle_q <= 1'b0;
        end else if (commit) begin
            wr_toggle_q <= ~wr_toggle_q;
        end
    end

    // Pin only ever pulled low or released
    assign o_sda_out = 1'b0;
    assign o_sda_oe_n = ~drive_low_q;

endmodule // eeprom_serial_slave

// [eeprom_serial_slave_assertions.sv]
// Port checks of the serial EEPROM slave
`timescale 1ns/10ps
module eeprom_serial_slave_assertions #(
    parameter int INIT_CYCLES = 20,
    parameter int WRITE_CYCLES = 200
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_link_clock,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_supply_low,
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n,
    input wire logic o_init_done,
    input wire logic o_write_busy
);
    ////////////////////////////////////////////////////////////////////////
    // Slack of two edges covers the output register
    logic [19:0] run_q;
    logic [19:0] busy_q;
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) run_q <= 20'h00000;
        else if (!o_init_done) run_q <= run_q + 20'h00001;
    end
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) busy_q <= 20'h00000;
        else busy_q <= o_write_busy ? busy_q + 20'h00001 : 20'h00000;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence drive_on;
        $fell(o_sda_oe_n);
    endsequence
    sequence drive_held;
        !o_sda_oe_n [*8];
    endsequence
    drive_hold_a: assert property (
        @(posedge i_link_clock) disable iff (!i_rstn) drive_on |-> drive_held)
        else $error("drive dropped early");
    open_drain_a: assert property (
        @(posedge i_link_clock) disable iff (!i_rstn) o_sda_out == 1'b0)
        else $error("data driven high");
    edge_safe_a: assert property (
        @(posedge i_link_clock) disable iff (!i_rstn)
        $changed(o_sda_oe_n) |-> !i_scl) else $error("drive moved, clock high");
    init_lock_a: assert property (
        @(posedge i_link_clock) disable iff (!i_rstn)
        !o_init_done |-> o_sda_oe_n) else $error("answer during init");
    init_time_a: assert property (
        @(posedge i_clock) disable iff (!i_rstn) $rose(o_init_done) |->
        run_q >= INIT_CYCLES - 2 && run_q <= INIT_CYCLES + 2)
        else $error("init length wrong");
    busy_quiet_a: assert property (
        @(posedge i_clock) disable iff (!i_rstn) o_write_busy |-> o_sda_oe_n)
        else $error("answer during write");
    busy_len_a: assert property (
        @(posedge i_clock) disable iff (!i_rstn) $fell(o_write_busy) |->
        busy_q >= WRITE_CYCLES - 2 && busy_q <= WRITE_CYCLES + 2)
        else $error("write length wrong");
    busy_cause_a: assert property (
        @(posedge i_clock) disable iff (!i_rstn) $rose(o_write_busy) |->
        !i_supply_low && i_scl && i_sda) else $error("write without stop");
endmodule // eeprom_serial_slave_assertions
bind eeprom_serial_slave eeprom_serial_slave_assertions #(
    .INIT_CYCLES(INIT_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)
) u_eeprom_serial_slave_assertions (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_link_clock(i_link_clock), .i_scl(i_scl), .i_sda(i_sda),
    .i_supply_low(i_supply_low), .o_sda_out(o_sda_out),
    .o_sda_oe_n(o_sda_oe_n), .o_init_done(o_init_done),
    .o_write_busy(o_write_busy));

// [bus_master.sv]
// Two-wire bus master model
`timescale 1ns/10ps
module bus_master (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    // 300 ns quarter bit leaves room for the filtered reply
    localparam int Q = 15;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic q();
        repeat (Q) @(negedge i_clk);
    endtask
    // Data moves with clock low; a != b makes a condition
    task automatic phase(input logic a, input logic b, output logic r);
        o_scl = 1'b0;
        q();
        o_sda = a;
        q();
        o_scl = 1'b1;
        q();
        r = i_sda;
        o_sda = b;
        q();
    endtask
    task automatic glitch(input logic on_sda);
        if (on_sda) o_sda = ~o_sda;
        else o_scl = ~o_scl;
        repeat (8) @(negedge i_clk);
        if (on_sda) o_sda = ~o_sda;
        else o_scl = ~o_scl;
    endtask
    task automatic wbyte(input logic [7:0] v, input logic g, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            phase(v[i], v[i], r);
            if (g) glitch(1'b0);
            if (g) glitch(1'b1);
        end
        phase(1'b1, 1'b1, ack);
    endtask
    task automatic rbyte(input logic nak, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) phase(1'b1, 1'b1, v[i]);
        phase(nak, nak, r);
    endtask
endmodule // bus_master

// [tb_top.sv]
// Self-checking bench for the serial EEPROM slave
`timescale 1ns/10ps
module tb_top;
    localparam int INIT_N = 2000;
    localparam int WRITE_N = 2000;
    logic i_clock = 1'b0;
    logic i_link_clock = 1'b0;
    logic i_rstn = 1'b0;
    logic i_supply_low = 1'b0;
    logic [2:0] pins = 3'h0;
    logic scl, m_sda, sda, sda_out, oe_n, init_done, busy;
    logic [7:0] mem [256];
    int fail_count = 0;
    int samples_checked = 0;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    fail_count++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
    // Pull-up on the wire
    assign sda = oe_n ? m_sda : sda_out;
    initial forever #10 i_clock = ~i_clock;
    initial begin
        #3.3;
        forever #6 i_link_clock = ~i_link_clock;
    end
    eeprom_serial_slave #(.INIT_CYCLES(INIT_N), .WRITE_CYCLES(WRITE_N))
        u_eeprom_serial_slave (.i_clock(i_clock), .i_rstn(i_rstn),
        .i_link_clock(i_link_clock), .i_scl(scl), .i_sda(sda),
        .o_sda_out(sda_out), .o_sda_oe_n(oe_n), .i_addr_pins(pins),
        .i_supply_low(i_supply_low), .o_init_done(init_done),
        .o_write_busy(busy));
    bus_master u_bus_master (.i_clk(i_clock), .i_sda(sda), .o_scl(scl),
        .o_sda(m_sda));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pg(input logic [7:0] a, input int i);
        return {a[7:4], a[3:0] + 4'(i)};
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic sel(input logic [2:0] p, input logic rw, output logic ack);
        logic r;
        u_bus_master.phase(1'b1, 1'b0, r);
        u_bus_master.wbyte({eeprom_slave_pkg::DEVICE_TYPE_DEF, p, rw}, 1'b0, ack);
    endtask
    task automatic stop();
        logic r;
        u_bus_master.phase(1'b0, 1'b1, r);
    endtask
    task automatic settle(input logic exp);
        logic ack;
        int k;
        repeat (50) @(negedge i_clock);
        `CHK("busy", exp, busy)
        if (exp) begin
            sel(pins, 1'b1, ack);
            `CHK("busy ack", 1'b1, ack)
            stop();
        end
        for (k = 0; k < WRITE_N && busy !== 1'b0; k++) @(negedge i_clock);
        if (k == WRITE_N) begin
            `CHK("busy end", 1'b0, busy)
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input int n, input logic lo,
        input logic g);
        logic ack;
        logic [7:0] d;
        sel(pins, 1'b0, ack);
        `CHK("select ack", 1'b0, ack)
        u_bus_master.wbyte(a, 1'b0, ack);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            u_bus_master.wbyte(d, g, ack);
            `CHK("data ack", 1'b0, ack)
            if (!lo) mem[pg(a, i)] = d;
        end
        i_supply_low = lo;
        stop();
        settle(n > 0 && !lo);
        i_supply_low = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        logic ack;
        logic [7:0] v;
        sel(pins, 1'b0, ack);
        u_bus_master.wbyte(a, 1'b0, ack);
        sel(pins, 1'b1, ack);
        for (int i = 0; i < n; i++) begin
            u_bus_master.rbyte(i == n - 1, v);
            `CHK("read data", mem[8'(a + i)], v)
        end
        stop();
    endtask
    task automatic cut(input int nb, input logic rs);
        logic ack, r;
        logic [7:0] d;
        d = 8'($urandom);
        sel(pins, 1'b0, ack);
        u_bus_master.wbyte(8'h42, 1'b0, ack);
        for (int i = 0; i < nb; i++) u_bus_master.phase(d[i], d[i], r);
        if (rs) u_bus_master.phase(1'b1, 1'b0, r);
        stop();
        settle(1'b0);
    endtask
    task automatic recover();
        logic r;
        u_bus_master.phase(1'b1, 1'b0, r);
        for (int i = 0; i < 9; i++) u_bus_master.phase(1'b1, 1'b1, r);
        `CHK("released", 1'b1, oe_n)
        u_bus_master.phase(1'b1, 1'b0, r);
        stop();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic ack;
        logic [7:0] a;
        a = 8'($urandom(32'h01A7));
        pins = 3'($urandom);
        repeat (12) @(negedge i_clock);
        i_rstn = 1'b1;
        sel(pins, 1'b0, ack);
        `CHK("init ack", 1'b1, ack)
        stop();
        repeat (INIT_N) @(negedge i_clock);
        `CHK("init done", 1'b1, init_done)
        recover();
        $display("test init done");
        wr(8'hFF, 17, 1'b0, 1'b0);
        wr(8'h00, 1, 1'b0, 1'b0);
        rd(8'hFF, 2);
        $display("test wrap done");
        sel(~pins, 1'b0, ack);
        `CHK("foreign ack", 1'b1, ack)
        stop();
        wr(8'h42, 2, 1'b0, 1'b0);
        wr(8'h42, 2, 1'b1, 1'b0);
        cut(0, 1'b0);
        cut(1, 1'b0);
        cut(7, 1'b0);
        cut(4, 1'b1);
        cut(0, 1'b1);
        rd(8'h42, 2);
        $display("test refused writes done");
        a = {a[7:4], 4'h3};
        wr(a, 3, 1'b0, 1'b1);
        rd(a, 3);
        $display("test glitch done");
        a = 8'hF0;
        while (mem[a][7] !== 1'b0 && a < 8'hFF) a++;
        sel(pins, 1'b0, ack);
        u_bus_master.wbyte(a, 1'b0, ack);
        sel(pins, 1'b1, ack);
        recover();
        rd(a, 1);
        $display("test recovery done");
        final_report();
    end
endmodule // tb_top
